// *** pkg/lomix_pkg.sv ***
// Package for the left line output mixer register bank.
// Assumes 8-bit registers on a plain address/strobe port, byte addresses as printed.
package lomix_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_ROUTE = 7;
  // Register offsets.
  localparam logic [7:0] RESERVED_PRE_MIXER = 8'h4F;
  localparam logic [7:0] LINE_B_LEFT_TO_LEFT_OUT_VOL = 8'h50;
  localparam logic [7:0] GAIN_LEFT_TO_LEFT_OUT_VOL = 8'h51;
  localparam logic [7:0] CONV_LEFT_TO_LEFT_OUT_VOL = 8'h52;
  localparam logic [7:0] LINE_B_RIGHT_TO_LEFT_OUT_VOL = 8'h53;
  localparam logic [7:0] GAIN_RIGHT_TO_LEFT_OUT_VOL = 8'h54;
  localparam logic [7:0] CONV_RIGHT_TO_LEFT_OUT_VOL = 8'h55;
  localparam logic [7:0] LEFT_OUT_LEVEL_CTRL = 8'h56;
  localparam logic [7:0] LINE_B_LEFT_TO_RIGHT_OUT_VOL = 8'h57;
  // Field positions.
  localparam int unsigned ROUTE_EN_BIT = 7;
  localparam int unsigned ATTEN_MSB = 6;
  localparam int unsigned LEVEL_MSB = 7;
  localparam int unsigned LEVEL_LSB = 4;
  localparam int unsigned MUTE_OFF_BIT = 3;
  localparam int unsigned PENDING_BIT = 1;
  localparam int unsigned POWERED_BIT = 0;
  // Reset values.
  localparam logic [7:0] RESERVED_VALUE = 8'h00;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic MUTE_OFF_RESET = 1'b0;
  localparam logic PENDING_RESET = 1'b1;
  localparam logic POWERED_RESET = 1'b0;
  localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage

// *** logic/lomix_regs.sv ***
// Register bank for the left line output mixer and the first right output route.
// Assumes a register port on core_clk_i and asynchronous status from the analog side.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// - Reserved register reads zero, writes ignored.
// - Left line B route enable bit 7.
// - Left gain stage route enable bit 7.
// - Left converter route enable bit 7.
// - Right line B route enable bit 7.
// - Right gain stage route enable bit 7.
// - Right converter route enable bit 7.
// - Left line B to right output enable.
// - Seven-bit attenuation per route, reset zero.
// - Level code bits 7:4, 1 dB steps.
// - Bit 3 set unmutes, resets muted.
// - Bit 2 read-only zero.
// - Bit 1 shows gain still pending.
// - Bit 0 shows driver fully powered.
module lomix_regs (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Analog status inputs.
  input wire logic gain_pending_i,
  input wire logic out_powered_i,
  // Analog controls: index 0..5 feed the left output, 6 the right output.
  output logic [6:0] route_en_o,
  output logic [48:0] atten_o,
  output logic [3:0] left_out_level_o,
  output logic left_out_unmute_o
);

  ////////////////////////////////////////////////////////////////////////////////

  // Register storage: each route keeps its enable bit and attenuation code apart.
  logic [6:0] route_en_q;
  logic [6:0] route_atten [lomix_pkg::NUM_ROUTE];
  logic [3:0] level;
  logic unmute;

  // Write decode and the fields of the write word.
  logic hit_level;
  logic [6:0] hit_route;
  logic wr_level;
  logic [6:0] wr_route;
  logic wr_en_bit;
  logic [6:0] wr_atten;
  logic [3:0] wr_level_code;
  logic wr_unmute;

  // Status synchronisers; index 1 carries pending, index 0 powered.
  logic [1:0] status_raw;
  logic [2:0] status_sync [2];
  logic [1:0] status_agree;
  logic [1:0] status_q;
  logic pending;
  logic powered;

  // Read path.
  logic [7:0] level_word;
  logic [7:0] next_rdata;

  // Register address for each route table index.
  function automatic logic [7:0] route_addr(input int unsigned idx);
    case (idx)
      0: route_addr = lomix_pkg::LINE_B_LEFT_TO_LEFT_OUT_VOL;
      1: route_addr = lomix_pkg::GAIN_LEFT_TO_LEFT_OUT_VOL;
      2: route_addr = lomix_pkg::CONV_LEFT_TO_LEFT_OUT_VOL;
      3: route_addr = lomix_pkg::LINE_B_RIGHT_TO_LEFT_OUT_VOL;
      4: route_addr = lomix_pkg::GAIN_RIGHT_TO_LEFT_OUT_VOL;
      5: route_addr = lomix_pkg::CONV_RIGHT_TO_LEFT_OUT_VOL;
      default: route_addr = lomix_pkg::LINE_B_LEFT_TO_RIGHT_OUT_VOL;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  // Write decode. Each register owns one hit line, so a write lands only where it names;
  // the reserved slot and unmapped addresses get no write enable at all.
  always_comb begin
    hit_level = 1'b0;
    if (addr_i == lomix_pkg::LEFT_OUT_LEVEL_CTRL) begin
      hit_level = 1'b1;
    end
  end

  assign wr_level = wr_i && hit_level;

  genvar gd;
  generate
    for (gd = 0; gd < lomix_pkg::NUM_ROUTE; gd++) begin : g_decode
      assign hit_route[gd] = (addr_i == route_addr(gd));
      assign wr_route[gd] = wr_i && hit_route[gd];
    end
  endgenerate

  // Fields of the write word; bits 2:0 of a level write have no home and are dropped.
  assign wr_en_bit = wdata_i[lomix_pkg::ROUTE_EN_BIT];
  assign wr_atten = wdata_i[lomix_pkg::ATTEN_MSB:0];
  assign wr_level_code = wdata_i[lomix_pkg::LEVEL_MSB:lomix_pkg::LEVEL_LSB];
  assign wr_unmute = wdata_i[lomix_pkg::MUTE_OFF_BIT];

  ////////////////////////////////////////////////////////////////////////////////

  // Routes. The switch and the attenuator of one path change at the same edge.
  genvar gi;
  generate
    for (gi = 0; gi < lomix_pkg::NUM_ROUTE; gi++) begin : g_route
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          route_en_q[gi] <= lomix_pkg::ROUTE_RESET[lomix_pkg::ROUTE_EN_BIT];
        end else if (wr_route[gi]) begin
          route_en_q[gi] <= wr_en_bit;
        end
      end

      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          route_atten[gi] <= lomix_pkg::ROUTE_RESET[lomix_pkg::ATTEN_MSB:0];
        end else if (wr_route[gi]) begin
          route_atten[gi] <= wr_atten;
        end
      end

      assign route_en_o[gi] = route_en_q[gi];
      assign atten_o[gi*7 +: 7] = route_atten[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////

  // Level code. Reserved codes above nine are stored and driven as written; the bank does
  // not police them, which keeps readback equal to what software wrote.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level <= lomix_pkg::LEVEL_RESET;
    end else if (wr_level) begin
      level <= wr_level_code;
    end
  end

  // Mute. Zero after reset, so the output wakes up silent.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unmute <= lomix_pkg::MUTE_OFF_RESET;
    end else if (wr_level) begin
      unmute <= wr_unmute;
    end
  end

  assign left_out_level_o = level;
  assign left_out_unmute_o = unmute;

  ////////////////////////////////////////////////////////////////////////////////

  // Status from the analog side. Each bit passes three flops and is taken only once the
  // second and third agree, so one metastable sample cannot reach the register port.
  assign status_raw[lomix_pkg::PENDING_BIT] = gain_pending_i;
  assign status_raw[lomix_pkg::POWERED_BIT] = out_powered_i;

  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++) begin : g_status
      // Pending wakes up set, powered wakes up clear.
      localparam logic [2:0] SYNC_INIT = (gs == lomix_pkg::PENDING_BIT) ?
          {3{lomix_pkg::PENDING_RESET}} : lomix_pkg::SYNC_RESET;
      localparam logic Q_INIT = (gs == lomix_pkg::PENDING_BIT) ?
          lomix_pkg::PENDING_RESET : lomix_pkg::POWERED_RESET;

      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          status_sync[gs] <= SYNC_INIT;
        end else begin
          status_sync[gs] <= {status_sync[gs][1:0], status_raw[gs]};
        end
      end

      assign status_agree[gs] = (status_sync[gs][1] == status_sync[gs][2]);

      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          status_q[gs] <= Q_INIT;
        end else if (status_agree[gs]) begin
          status_q[gs] <= status_sync[gs][2];
        end
      end
    end
  endgenerate

  assign pending = status_q[lomix_pkg::PENDING_BIT];
  assign powered = status_q[lomix_pkg::POWERED_BIT];

  ////////////////////////////////////////////////////////////////////////////////

  // Readback word of the level register; bit 2 has no source and always reads zero.
  always_comb begin
    level_word = 8'h00;
    level_word[lomix_pkg::LEVEL_MSB:lomix_pkg::LEVEL_LSB] = level;
    level_word[lomix_pkg::MUTE_OFF_BIT] = unmute;
    level_word[lomix_pkg::PENDING_BIT] = pending;
    level_word[lomix_pkg::POWERED_BIT] = powered;
  end

  // Read mux. Unmapped addresses fall to the default and read zero.
  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      lomix_pkg::RESERVED_PRE_MIXER: begin
        next_rdata = lomix_pkg::RESERVED_VALUE;
      end
      lomix_pkg::LINE_B_LEFT_TO_LEFT_OUT_VOL: begin
        next_rdata = {route_en_q[0], route_atten[0]};
      end
      lomix_pkg::GAIN_LEFT_TO_LEFT_OUT_VOL: begin
        next_rdata = {route_en_q[1], route_atten[1]};
      end
      lomix_pkg::CONV_LEFT_TO_LEFT_OUT_VOL: begin
        next_rdata = {route_en_q[2], route_atten[2]};
      end
      lomix_pkg::LINE_B_RIGHT_TO_LEFT_OUT_VOL: begin
        next_rdata = {route_en_q[3], route_atten[3]};
      end
      lomix_pkg::GAIN_RIGHT_TO_LEFT_OUT_VOL: begin
        next_rdata = {route_en_q[4], route_atten[4]};
      end
      lomix_pkg::CONV_RIGHT_TO_LEFT_OUT_VOL: begin
        next_rdata = {route_en_q[5], route_atten[5]};
      end
      lomix_pkg::LINE_B_LEFT_TO_RIGHT_OUT_VOL: begin
        next_rdata = {route_en_q[6], route_atten[6]};
      end
      lomix_pkg::LEFT_OUT_LEVEL_CTRL: begin
        next_rdata = level_word;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Read data stands only in the cycle after the strobe and is zero otherwise, so a
  // master that samples late sees an obvious zero rather than stale data.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // lomix_regs

// *** dv/lomix_regs_sva.sv ***
// Checker for the mixer register bank.
// Sees only the ports of lomix_regs; the bind stands after the module.
`timescale 1ns/1ps
module lomix_regs_sva (
  input wire logic core_clk_i, rst_b_i, wr_i, rd_i,
  input wire logic gain_pending_i, out_powered_i, left_out_unmute_o,
  input wire logic [7:0] addr_i, wdata_i, rdata_o,
  input wire logic [6:0] route_en_o,
  input wire logic [48:0] atten_o,
  input wire logic [3:0] left_out_level_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_route_first: assert property (wr_i && addr_i == 8'h50 |=>
    {route_en_o[0], atten_o[6:0]} == $past(wdata_i)) else $error("first route wrong");
  a_route_right: assert property (wr_i && addr_i == 8'h57 |=>
    {route_en_o[6], atten_o[48:42]} == $past(wdata_i)) else $error("right route wrong");
  a_level_wr: assert property (wr_i && addr_i == 8'h56 |=>
    {left_out_level_o, left_out_unmute_o, 3'h0} == ($past(wdata_i) & 8'hF8))
    else $error("level or mute wrong");
  a_rsvd_zero: assert property (rd_i && addr_i == 8'h4F |=> rdata_o == 8'h00)
    else $error("reserved not zero");
  a_bit2_zero: assert property (rd_i && addr_i == 8'h56 |=> !rdata_o[2])
    else $error("bit 2 set");
  // Six quiet samples let the status through its synchroniser first.
  a_status_in: assert property (($stable(gain_pending_i) && $stable(out_powered_i))[*6]
    ##0 rd_i && addr_i == 8'h56 |=> rdata_o[1:0] == {$past(gain_pending_i),
    $past(out_powered_i)}) else $error("status wrong");
  a_hold_quiet: assert property (!wr_i |=> $stable(route_en_o) && $stable(atten_o)
    && $stable(left_out_level_o)) else $error("control moved");
  a_read_back: assert property (rd_i && addr_i == 8'h57 |=>
    rdata_o == {$past(route_en_o[6]), $past(atten_o[48:42])}) else $error("readback");
endmodule // lomix_regs_sva
bind lomix_regs lomix_regs_sva u_sva (.core_clk_i, .rst_b_i, .wr_i, .rd_i, .gain_pending_i,
  .out_powered_i, .left_out_unmute_o, .addr_i, .wdata_i, .rdata_o, .route_en_o, .atten_o,
  .left_out_level_o);

// *** dv/lomix_regs_tb.sv ***
// Self-checking bench for the mixer register bank.
// Drives the register port and both status inputs itself.
`timescale 1ns/1ps
module lomix_regs_tb;
  logic core_clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0;
  logic gain_pending_i = 1, out_powered_i = 0, left_out_unmute_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [6:0] route_en_o;
  logic [48:0] atten_o, e;
  logic [3:0] left_out_level_o;
  int num_errors = 0, checks_done = 0, cyc = 0;
  logic [7:0] ra [7] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h57};
  always #5 core_clk_i = ~core_clk_i;
  lomix_regs u_dut (.core_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .gain_pending_i, .out_powered_i, .route_en_o, .atten_o, .left_out_level_o,
    .left_out_unmute_o);
  ////////////////////////////////////////
  task chk(input logic [63:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Strobes are set together so no task assigns one twice in a step.
  task wr(input logic [7:0] a, d);
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
  endtask
  task rd(input logic [7:0] a, x);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, x);
    @(posedge core_clk_i);
  endtask
  task idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge core_clk_i);
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_routes;
    for (int i = 0; i < 7; i++) wr(ra[i], 8'h80 | 8'(i * 9 + 3));
    idle(1);
    for (int i = 0; i < 7; i++) e[7*i+:7] = 7'(i * 9 + 3);
    #1 chk({route_en_o, atten_o}, {7'h7F, e});
    for (int i = 0; i < 7; i++) rd(ra[i], 8'h80 | 8'(i * 9 + 3));
    wr(8'h51, 8'h00);
    rd(8'h51, 8'h00);
    chk(route_en_o, 7'h7D);
  endtask
  task t_level;
    wr(8'h90, 8'hFF);
    rd(8'h4F, 8'h00);
    rd(8'h90, 8'h00);
    wr(8'h56, 8'h9B);
    idle(1);
    gain_pending_i <= 1'b0;
    out_powered_i <= 1'b1;
    chk({left_out_level_o, left_out_unmute_o}, 5'h13);
    idle(8);
    rd(8'h56, 8'h99);
    wr(8'h56, 8'h03);
    rd(8'h56, 8'h01);
  endtask
  task t_reset;
    rst_b_i <= 1'b0;
    #1 chk({route_en_o, atten_o, left_out_level_o, left_out_unmute_o}, 0);
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    rd(8'h56, 8'h02);
    rd(8'h57, 8'h00);
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < 7; i++) rd(ra[i], 8'h00);
    rd(8'h56, 8'h02);
    t_routes();
    t_level();
    t_reset();
    finish_test();
  end
endmodule // lomix_regs_tb
